/* tb/wave_load.sv */
`default_nettype none
// Loads on the channel pins; counts level changes per channel
module wave_load (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [5:0] wave_out,
  output int             edges [6]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] last_q;
  always @(posedge pclk) begin
    last_q <= wave_out;
    for (int i = 0; i < 6; i++) begin
      if (!presetn) edges[i] <= 0;
      else if (wave_out[i] !== last_q[i]) edges[i] <= edges[i] + 1;
    end
  end
endmodule
`default_nettype wire

/* tb/waveform_actions_assertions.sv */
`default_nettype none
module waveform_actions_assertions (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Channels
  input wire logic [5:0]  wave_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr inside {8'h30, 8'h34, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64,
                              8'h90, 8'hb0, 8'hb4};
  wire rd_ok  = pready && !pwrite;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_unmapped: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("no error on unmapped");
  a_no_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_status_layout: assert property (rd_ok && paddr == 8'h90 |-> prdata[31:17] == 15'h0)
    else $error("status reserved bits");
  a_action_layout: assert property (rd_ok && paddr[7:4] == 4'hb
    |-> prdata[31:28] == 4'h0 && prdata[15:12] == 4'h0)
    else $error("action reserved bits");
  a_unmapped_zero: assert property (rd_ok && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data");
endmodule
bind waveform_actions waveform_actions_assertions i_waveform_actions_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .wave_out);
`default_nettype wire

/* tb/waveform_actions_tb.sv */
`default_nettype none
module waveform_actions_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd, r1;
  logic        err;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr;
  wire logic [5:0]  wave_out;
  int edges[6], e0[6], hi[6], c[6], n_mismatch = 0, n_compared = 0, p, j, eh;
  logic [2:0]  md[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h1};
  logic [31:0] w0[6] = '{32'h555, 32'haaa, 32'h05550aaa, 32'h555, 32'haaa, 32'h0aaa0000};
  logic [31:0] w1[6] = '{32'haaa, 32'h05550000, 32'h0, 32'h888, 32'h04440000, 32'h05550000};
  waveform_actions i_waveform_actions (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .wave_out);
  wave_load i_wave_load (.pclk, .presetn, .wave_out, .edges(edges));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task finish_test;
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    void'($urandom(32'haec8));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h90, 0);
    chk(rd, 32'h00010000);
    for (int k = 0; k < 2; k++) begin
      apb(0, 8'hb0 + 4 * k, 0);
      chk(rd, 32'h0);
      r1 = $urandom;
      apb(1, 8'hb0 + 4 * k, r1);
      apb(0, 8'hb0 + 4 * k, 0);
      chk(rd, r1 & 32'h0fff0fff);
    end
    apb(0, 8'h10, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1, 8'h90, 32'hffffffff);
    chk(err, 1'b0);
    apb(1, 8'h30, 32'd9);
    for (int i = 0; i < 6; i++) begin
      c[i] = (i == 0) ? 0 : 1 + $urandom % 8;
      apb(1, 8'h50 + 4 * i, c[i]);
    end
    for (int s = 0; s < 6; s++) begin
      apb(1, 8'h34, md[s]);
      apb(1, 8'hb0, w0[s]);
      apb(1, 8'hb4, w1[s]);
      repeat (40) @(posedge pclk);
      p = (md[s][1:0] == 2'h2) ? 18 : 10;
      for (int i = 0; i < 6; i++) begin
        e0[i] = edges[i];
        hi[i] = 0;
      end
      repeat (p) begin
        @(posedge pclk);
        for (int i = 0; i < 6; i++) hi[i] += wave_out[i];
      end
      for (int i = 0; i < 6; i++) begin
        j = md[s][2] ? (i | 1) : i;
        eh = (md[s][1:0] == 2'h2) ? 9 : (w0[s][27:16] != 0) ? 9 - c[j] :
             (md[s][0] && c[j] == 0) ? 0 : 10 - c[j];
        chk(hi[i], eh);
        chk(edges[i] - e0[i], (eh == 0 || eh == p) ? 0 : 2);
      end
      if (md[s][1:0] != 2'h2) begin
        apb(0, 8'h90, 0);
        r1 = rd;
        apb(0, 8'h90, 0);
        chk(rd[16], !md[s][0]);
        j = md[s][0] ? r1[15:0] - rd[15:0] : rd[15:0] - r1[15:0];
        chk((j + 10) % 10, 3);
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire

/* verilog/channel_action.v */
`include "waveform_regs.vh"
`default_nettype none

// One channel's output level, driven by the point actions of one cycle
module channel_action (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Point events and their actions
  input  wire        zero_hit,
  input  wire        top_hit,
  input  wire        cmp_up_hit,
  input  wire        cmp_dn_hit,
  input  wire        cmp2_up_hit,
  input  wire        cmp2_dn_hit,
  input  wire [1:0]  zero_act,
  input  wire [1:0]  top_act,
  input  wire [1:0]  up_act,
  input  wire [1:0]  dn_act,
  input  wire [1:0]  up2_act,
  input  wire [1:0]  dn2_act,
  // Level
  output reg         level_q
);

  reg level_d;

  function apply_act;
    input       cur;
    input [1:0] act;
    begin
      case (act)
        `ACT_LOW:    apply_act = 1'b0;
        `ACT_HIGH:   apply_act = 1'b1;
        `ACT_TOGGLE: apply_act = ~cur;
        default:     apply_act = cur;
      endcase
    end
  endfunction

  // Events apply in turn: zero, top, own compare, partner compare; do-nothing keeps the level
  always @* begin
    level_d = level_q;
    if (zero_hit)
      level_d = apply_act(level_d, zero_act);
    if (top_hit)
      level_d = apply_act(level_d, top_act);
    if (cmp_up_hit)
      level_d = apply_act(level_d, up_act);
    if (cmp_dn_hit)
      level_d = apply_act(level_d, dn_act);
    if (cmp2_up_hit)
      level_d = apply_act(level_d, up2_act);
    if (cmp2_dn_hit)
      level_d = apply_act(level_d, dn2_act);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      level_q <= 1'b0;
    else
      level_q <= level_d;
  end

endmodule

`default_nettype wire

/* verilog/waveform_actions.v */
// How it works
// - The live 16-bit counter reads in bits 15:0 of the counter status register.
// - Bit 16 of the counter status register reads one while counting up, zero while down.
// - Each channel's zero-point field sets no change, low, high or toggle at counter zero.
// - Each channel's top-point field sets the same four actions at the top point.
// - The top-point action is applied on the cycle after the counter holds the top value in up counting, and after it holds zero in down counting.
// - In up-down counting the top-point action is applied where counting turns downward.
// - The compare-down field acts when the counter, counting down, equals the compare value.
// - The compare-up field acts when the counter, counting up, equals the compare value.
// - In complementary mode odd channels' compare-down fields also drive the even partner.
// - In complementary mode odd channels' compare-up fields also drive the even partner.
// - The counter runs 0..top in up, top..0 in down, and 0..top..0 in up-down counting.
// - In complementary mode even compare values are first and odd ones second points.
//
// The APB register port was chosen for this implementation.
`include "waveform_regs.vh"
`default_nettype none

module waveform_actions (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Channel outputs
  output wire [5:0]  wave_out
);

  // Registers
  reg  [15:0] top_value_q;
  reg  [1:0]  cnt_type_q;
  reg         compl_q;
  reg  [11:0] zero_act_q;
  reg  [11:0] top_act_q;
  reg  [11:0] up_act_q;
  reg  [11:0] dn_act_q;
  reg  [15:0] cmp_q [0:5];
  reg  [15:0] counter_value_q;
  reg         dir_up_q;
  reg         top_pend_q;

  wire        setup_ph;
  wire        wr_en;
  wire        addr_ok;
  wire [2:0]  cmp_idx;
  reg  [31:0] rd_d;
  reg  [15:0] cnt_d;
  reg         dir_d;
  reg         top_pend_d;
  wire [5:0]  level;
  wire        zero_hit;
  wire        center_hit;
  wire        top_hit;
  wire [5:0]  cmp_eq;
  wire [5:0]  own_up;
  wire [5:0]  own_dn;
  wire [5:0]  mate_up;
  wire [5:0]  mate_dn;
  integer     i;

  function [1:0] field;
    input [11:0] bank;
    input [2:0]  ch;
    begin
      field = bank[ch*2 +: 2];
    end
  endfunction

  function is_cmp_addr;
    input [7:0] a;
    begin
      is_cmp_addr = (a >= `OFF_CMP_BASE) && (a <= `OFF_CMP_LAST) && (a[1:0] == 2'h0);
    end
  endfunction

  // Answer one cycle after setup, so every access takes two cycles
  assign setup_ph = psel && !penable;
  assign cmp_idx  = paddr[4:2] - 3'h4;
  assign addr_ok  = (paddr == `OFF_COUNTER_STATUS) || (paddr == `OFF_ZERO_PERIOD_ACT) ||
                    (paddr == `OFF_COMPARE_ACT) || (paddr == `OFF_TOP_VALUE) ||
                    (paddr == `OFF_MODE_CTRL) || is_cmp_addr(paddr);
  assign wr_en    = psel && penable && pready && pwrite && addr_ok;

  always @* begin
    rd_d = `RST_WORD;
    if (paddr == `OFF_COUNTER_STATUS)
      rd_d = {15'h0000, dir_up_q, counter_value_q};
    else if (paddr == `OFF_ZERO_PERIOD_ACT)
      rd_d = {4'h0, top_act_q, 4'h0, zero_act_q};
    else if (paddr == `OFF_COMPARE_ACT)
      rd_d = {4'h0, dn_act_q, 4'h0, up_act_q};
    else if (paddr == `OFF_TOP_VALUE)
      rd_d = {16'h0000, top_value_q};
    else if (paddr == `OFF_MODE_CTRL)
      rd_d = {29'h00000000, compl_q, cnt_type_q};
    else if (is_cmp_addr(paddr))
      rd_d = {16'h0000, cmp_q[cmp_idx]};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !addr_ok;
      if (setup_ph && !pwrite)
        prdata <= rd_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_value_q <= `RST_HALF;
      cnt_type_q  <= `CNT_TYPE_UP;
      compl_q     <= 1'b0;
      zero_act_q  <= `RST_ACT;
      top_act_q   <= `RST_ACT;
      up_act_q    <= `RST_ACT;
      dn_act_q    <= `RST_ACT;
      for (i = 0; i < 6; i = i + 1)
        cmp_q[i] <= `RST_HALF;
    end else if (wr_en) begin
      if (paddr == `OFF_ZERO_PERIOD_ACT) begin
        zero_act_q <= pwdata[`ACT_FIELD_W-1:0];
        top_act_q  <= pwdata[`HALF_HI_LSB +: `ACT_FIELD_W];
      end else if (paddr == `OFF_COMPARE_ACT) begin
        up_act_q <= pwdata[`ACT_FIELD_W-1:0];
        dn_act_q <= pwdata[`HALF_HI_LSB +: `ACT_FIELD_W];
      end else if (paddr == `OFF_TOP_VALUE) begin
        top_value_q <= pwdata[15:0];
      end else if (paddr == `OFF_MODE_CTRL) begin
        cnt_type_q <= pwdata[`MODE_COUNT_LSB +: 2];
        compl_q    <= pwdata[`MODE_COMPL_BIT];
      end else if (is_cmp_addr(paddr)) begin
        cmp_q[cmp_idx] <= pwdata[15:0];
      end
    end
  end

  // Period counter
  always @* begin
    cnt_d      = counter_value_q;
    dir_d      = dir_up_q;
    top_pend_d = 1'b0;
    case (cnt_type_q)
      `CNT_TYPE_UP: begin
        dir_d = 1'b1;
        if (counter_value_q >= top_value_q) begin
          cnt_d      = 16'h0000;
          top_pend_d = 1'b1;
        end else
          cnt_d = counter_value_q + 16'h0001;
      end
      `CNT_TYPE_DOWN: begin
        dir_d = 1'b0;
        if (counter_value_q == 16'h0000 || counter_value_q > top_value_q)
          cnt_d = top_value_q;
        else
          cnt_d = counter_value_q - 16'h0001;
        top_pend_d = (counter_value_q == 16'h0000);
      end
      `CNT_TYPE_UPDOWN: begin
        if (dir_up_q) begin
          if (counter_value_q >= top_value_q) begin
            dir_d      = 1'b0;
            cnt_d      = (top_value_q == 16'h0000) ? 16'h0000 : top_value_q - 16'h0001;
          end else
            cnt_d = counter_value_q + 16'h0001;
        end else begin
          if (counter_value_q == 16'h0000) begin
            dir_d = 1'b1;
            cnt_d = (top_value_q == 16'h0000) ? 16'h0000 : 16'h0001;
          end else
            cnt_d = counter_value_q - 16'h0001;
        end
      end
      default: begin
        cnt_d = 16'h0000;
        dir_d = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_q <= `RST_HALF;
      dir_up_q        <= 1'b0;
      top_pend_q      <= 1'b0;
    end else begin
      counter_value_q <= cnt_d;
      dir_up_q        <= dir_d;
      top_pend_q      <= top_pend_d;
    end
  end

  // Events shared by all channels; the centre point acts on the top value itself
  assign zero_hit   = (counter_value_q == 16'h0000);
  assign center_hit = (cnt_type_q == `CNT_TYPE_UPDOWN) && dir_up_q &&
                      (counter_value_q >= top_value_q);
  assign top_hit    = top_pend_q || center_hit;

  // Compare matches split by direction; odd matches feed the even partner
  assign cmp_eq[0]  = (counter_value_q == cmp_q[0]);
  assign cmp_eq[1]  = (counter_value_q == cmp_q[1]);
  assign cmp_eq[2]  = (counter_value_q == cmp_q[2]);
  assign cmp_eq[3]  = (counter_value_q == cmp_q[3]);
  assign cmp_eq[4]  = (counter_value_q == cmp_q[4]);
  assign cmp_eq[5]  = (counter_value_q == cmp_q[5]);
  assign own_up     = cmp_eq & {6{dir_up_q}};
  assign own_dn     = cmp_eq & {6{!dir_up_q}};
  assign mate_up    = {1'b0, own_up[5], 1'b0, own_up[3], 1'b0, own_up[1]} &
                      {6{compl_q}};
  assign mate_dn    = {1'b0, own_dn[5], 1'b0, own_dn[3], 1'b0, own_dn[1]} &
                      {6{compl_q}};

  // Channel 0, second controls from channel 1
  channel_action u_act0 (
    .pclk        (pclk),
    .presetn     (presetn),
    .zero_hit    (zero_hit),
    .top_hit     (top_hit),
    .cmp_up_hit  (own_up[0]),
    .cmp_dn_hit  (own_dn[0]),
    .cmp2_up_hit (mate_up[0]),
    .cmp2_dn_hit (mate_dn[0]),
    .zero_act    (field(zero_act_q, 3'h0)),
    .top_act     (field(top_act_q, 3'h0)),
    .up_act      (field(up_act_q, 3'h0)),
    .dn_act      (field(dn_act_q, 3'h0)),
    .up2_act     (field(up_act_q, 3'h1)),
    .dn2_act     (field(dn_act_q, 3'h1)),
    .level_q     (level[0])
  );

  // Channel 1, never takes second controls
  channel_action u_act1 (
    .pclk        (pclk),
    .presetn     (presetn),
    .zero_hit    (zero_hit),
    .top_hit     (top_hit),
    .cmp_up_hit  (own_up[1]),
    .cmp_dn_hit  (own_dn[1]),
    .cmp2_up_hit (mate_up[1]),
    .cmp2_dn_hit (mate_dn[1]),
    .zero_act    (field(zero_act_q, 3'h1)),
    .top_act     (field(top_act_q, 3'h1)),
    .up_act      (field(up_act_q, 3'h1)),
    .dn_act      (field(dn_act_q, 3'h1)),
    .up2_act     (field(up_act_q, 3'h0)),
    .dn2_act     (field(dn_act_q, 3'h0)),
    .level_q     (level[1])
  );

  // Channel 2, second controls from channel 3
  channel_action u_act2 (
    .pclk        (pclk),
    .presetn     (presetn),
    .zero_hit    (zero_hit),
    .top_hit     (top_hit),
    .cmp_up_hit  (own_up[2]),
    .cmp_dn_hit  (own_dn[2]),
    .cmp2_up_hit (mate_up[2]),
    .cmp2_dn_hit (mate_dn[2]),
    .zero_act    (field(zero_act_q, 3'h2)),
    .top_act     (field(top_act_q, 3'h2)),
    .up_act      (field(up_act_q, 3'h2)),
    .dn_act      (field(dn_act_q, 3'h2)),
    .up2_act     (field(up_act_q, 3'h3)),
    .dn2_act     (field(dn_act_q, 3'h3)),
    .level_q     (level[2])
  );

  // Channel 3, never takes second controls
  channel_action u_act3 (
    .pclk        (pclk),
    .presetn     (presetn),
    .zero_hit    (zero_hit),
    .top_hit     (top_hit),
    .cmp_up_hit  (own_up[3]),
    .cmp_dn_hit  (own_dn[3]),
    .cmp2_up_hit (mate_up[3]),
    .cmp2_dn_hit (mate_dn[3]),
    .zero_act    (field(zero_act_q, 3'h3)),
    .top_act     (field(top_act_q, 3'h3)),
    .up_act      (field(up_act_q, 3'h3)),
    .dn_act      (field(dn_act_q, 3'h3)),
    .up2_act     (field(up_act_q, 3'h2)),
    .dn2_act     (field(dn_act_q, 3'h2)),
    .level_q     (level[3])
  );

  // Channel 4, second controls from channel 5
  channel_action u_act4 (
    .pclk        (pclk),
    .presetn     (presetn),
    .zero_hit    (zero_hit),
    .top_hit     (top_hit),
    .cmp_up_hit  (own_up[4]),
    .cmp_dn_hit  (own_dn[4]),
    .cmp2_up_hit (mate_up[4]),
    .cmp2_dn_hit (mate_dn[4]),
    .zero_act    (field(zero_act_q, 3'h4)),
    .top_act     (field(top_act_q, 3'h4)),
    .up_act      (field(up_act_q, 3'h4)),
    .dn_act      (field(dn_act_q, 3'h4)),
    .up2_act     (field(up_act_q, 3'h5)),
    .dn2_act     (field(dn_act_q, 3'h5)),
    .level_q     (level[4])
  );

  // Channel 5, never takes second controls
  channel_action u_act5 (
    .pclk        (pclk),
    .presetn     (presetn),
    .zero_hit    (zero_hit),
    .top_hit     (top_hit),
    .cmp_up_hit  (own_up[5]),
    .cmp_dn_hit  (own_dn[5]),
    .cmp2_up_hit (mate_up[5]),
    .cmp2_dn_hit (mate_dn[5]),
    .zero_act    (field(zero_act_q, 3'h5)),
    .top_act     (field(top_act_q, 3'h5)),
    .up_act      (field(up_act_q, 3'h5)),
    .dn_act      (field(dn_act_q, 3'h5)),
    .up2_act     (field(up_act_q, 3'h4)),
    .dn2_act     (field(dn_act_q, 3'h4)),
    .level_q     (level[5])
  );

  assign wave_out = level;

endmodule

`default_nettype wire

/* verilog/waveform_regs.vh */
`ifndef WAVEFORM_REGS_VH
`define WAVEFORM_REGS_VH

// Register byte offsets
`define OFF_COUNTER_STATUS  8'h90
`define OFF_ZERO_PERIOD_ACT 8'hb0
`define OFF_COMPARE_ACT     8'hb4
`define OFF_TOP_VALUE       8'h30
`define OFF_MODE_CTRL       8'h34
`define OFF_CMP_BASE        8'h50
`define OFF_CMP_LAST        8'h64

// Field positions
`define DIR_BIT             16
`define HALF_HI_LSB         16
`define ACT_FIELD_W         12
`define MODE_COUNT_LSB      0
`define MODE_COMPL_BIT      2

// Counter type encodings
`define CNT_TYPE_UP         2'h0
`define CNT_TYPE_DOWN       2'h1
`define CNT_TYPE_UPDOWN     2'h2

// Action encodings
`define ACT_NONE            2'h0
`define ACT_LOW             2'h1
`define ACT_HIGH            2'h2
`define ACT_TOGGLE          2'h3

// Reset values
`define RST_WORD            32'h00000000
`define RST_HALF            16'h0000
`define RST_ACT             12'h000

`endif
